// file: meter_consts.vh
// Purpose: Shared constants of the meter measurement settings block
// Assumes: 25 MHz main clock
// Notes:   Times are given in milliseconds, counts derived from them
`ifndef METER_CONSTS_VH
`define METER_CONSTS_VH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_KHZ          25000
`define HOLD_SHORT_MS    1000
`define HOLD_LONG_MS     3000
`define TICK_MS          100
`define HOLD_SHORT_CYC   (`HOLD_SHORT_MS * `CLK_KHZ)
`define HOLD_LONG_CYC    (`HOLD_LONG_MS * `CLK_KHZ)
`define TICK_CYC         (`TICK_MS * `CLK_KHZ)

// ---------------------------------------------------------------
// Setting levels (level indicator codes)
// ---------------------------------------------------------------
`define LVL_OPER         2'h0
`define LVL_INIT         2'h1
`define LVL_ADV          2'h2

// ---------------------------------------------------------------
// Parameter identifiers, bit 3 marks the advanced level
// ---------------------------------------------------------------
`define P_OUT1           4'h0
`define P_OUT2           4'h1
`define P_PWD            4'h2
`define P_AVG            4'h8
`define P_HYS1           4'h9
`define P_HYS2           4'hA
`define P_AZ             4'hB
`define P_SU             4'hC

// ---------------------------------------------------------------
// Field limits, encodings and reset values
// ---------------------------------------------------------------
`define PWD_VALUE        14'h00A9
`define MODE_UPPER       2'h0
`define MODE_LOWER       2'h1
`define MODE_OUTSIDE     2'h2
`define MODE_MAX         14'h0002
`define AVG_OFF          2'h0
`define AVG_MAX          14'h0003
`define HYS_MAX          14'h270F
`define AZ_MAX           14'h00C7
`define SU_MAX           14'h03E7
`define HYS_RESET        14'h0001
`define AZ_RESET         8'h32
`define SU_RESET         10'h000

`endif

// file: limit_comparator.v
// Purpose: One comparative output with hysteresis
// Assumes: Readout and limits are unsigned display digits
// Notes:   Updates on each readout strobe, off while disabled
`timescale 1ns/1ns
`include "meter_consts.vh"

module limit_comparator (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        sys_rst_in,
  input  wire        clk_en_in,
  // Measurement
  input  wire        enable_in,
  input  wire        sample_in,
  input  wire [15:0] readout_in,
  // Settings
  input  wire [15:0] limit_hi_in,
  input  wire [15:0] limit_lo_in,
  input  wire [13:0] hyst_in,
  input  wire [1:0]  mode_in,
  // Result
  output reg         active_out
);

  wire [13:0] eff_hyst;
  wire [16:0] read_plus;
  wire [16:0] lo_plus;
  wire        above;
  wire        below;
  wire        back_hi;
  wire        back_lo;
  reg         next_active;

  assign eff_hyst  = (hyst_in == 14'h0000) ? 14'h0001 : hyst_in;
  assign read_plus = {1'b0, readout_in} + {3'h0, eff_hyst};
  assign lo_plus   = {1'b0, limit_lo_in} + {3'h0, eff_hyst};
  assign above     = readout_in >= limit_hi_in;
  assign below     = readout_in <= limit_lo_in;
  assign back_hi   = read_plus <= {1'b0, limit_hi_in};
  assign back_lo   = {1'b0, readout_in} >= lo_plus;

  always @* begin
    next_active = active_out;
    case (mode_in)
      `MODE_UPPER: begin
        if (!active_out && above)
          next_active = 1'b1;
        else if (active_out && back_hi)
          next_active = 1'b0;
      end
      `MODE_LOWER: begin
        if (!active_out && below)
          next_active = 1'b1;
        else if (active_out && back_lo)
          next_active = 1'b0;
      end
      `MODE_OUTSIDE: begin
        if (!active_out && (above || below))
          next_active = 1'b1;
        else if (active_out && back_hi && back_lo)
          next_active = 1'b0;
      end
      default: next_active = 1'b0;
    endcase
  end

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      active_out <= 1'b0;
    else if (clk_en_in) begin
      if (!enable_in)
        active_out <= 1'b0;
      else if (sample_in)
        active_out <= next_active;
    end
  end

endmodule

// file: meter_measure_settings.v
// Purpose: Averaging, hysteresis outputs, auto-zero, start-up delay
//          and the key driven setting levels of a panel meter
// Assumes: Keys and pulse input are asynchronous pins, active high;
//          raw samples come from logic on mclk_in
// Notes:   Settings are volatile; reset loads the default values
// Behaviour
// - Averaging off or 2, 4, 8
// - Two hysteresis values, 0 to 9999
// - Hysteresis zero acts as one
// - Auto-zero time 0.0 to 19.9 s
// - Frequency variant: no pulse for timeout forces zero
// - Start-up time 0.0 to 99.9 s
// - Measuring enables on the first clock after reset; the start-up time never delays it
// - Three second hold enters initial level
// - One second hold moves up a level
// - Password opens advanced level
// - Shift shows, shift edits, advance saves
// - Level indicator shows level code
// - Outputs upper, lower or outside action
`timescale 1ns/1ns
`include "meter_consts.vh"

module meter_measure_settings #(
  parameter HOLD_SHORT_CYCLES = `HOLD_SHORT_CYC,
  parameter HOLD_LONG_CYCLES  = `HOLD_LONG_CYC,
  parameter TICK_CYCLES       = `TICK_CYC
) (
  // Clock, reset, enable
  input  wire        mclk_in,
  input  wire        sys_rst_in,
  input  wire        clk_en_in,
  // Operator keys (pins)
  input  wire        level_key_in,
  input  wire        mode_key_in,
  input  wire        shift_key_in,
  input  wire        up_key_in,
  // Variant strap (pin)
  input  wire        freq_variant_in,
  // Measurement input
  input  wire        pulse_in,
  input  wire        raw_valid_in,
  input  wire [15:0] raw_value_in,
  // Comparison limits
  input  wire [15:0] limit1_hi_in,
  input  wire [15:0] limit1_lo_in,
  input  wire [15:0] limit2_hi_in,
  input  wire [15:0] limit2_lo_in,
  // Readout and outputs
  output reg  [15:0] readout_out,
  output reg         readout_valid_out,
  output wire        out1_out,
  output wire        out2_out,
  output reg         measure_enable_out,
  // Front panel display
  output reg  [1:0]  level_code_out,
  output reg  [3:0]  param_sel_out,
  output reg         show_value_out,
  output reg         blink_out,
  output reg  [13:0] edit_value_out,
  // Current settings
  output reg  [1:0]  averaging_count,
  output reg  [13:0] hyst1_out,
  output reg  [13:0] hyst2_out,
  output reg  [7:0]  autozero_time_out,
  output reg  [9:0]  startup_delay_time,
  output reg  [1:0]  out1_mode_out,
  output reg  [1:0]  out2_mode_out
);

  // -------------------------------------------------------------
  // Pin synchronisers and edge detection
  // -------------------------------------------------------------
  reg  [5:0] sync_a;
  reg  [5:0] sync_b;
  reg  [5:0] sync_d;
  wire [5:0] rise;
  wire       lvl_key;
  wire       freq_var;

  assign rise     = sync_b & ~sync_d;
  assign lvl_key  = sync_b[0];
  assign freq_var = sync_b[5];

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      sync_d <= 6'h00;
    end else if (clk_en_in) begin
      sync_a <= {freq_variant_in, pulse_in, up_key_in, shift_key_in,
                 mode_key_in, level_key_in};
      sync_b <= sync_a;
      sync_d <= sync_b;
    end
  end

  // -------------------------------------------------------------
  // Tenth second tick
  // -------------------------------------------------------------
  reg  [31:0] tick_cnt;
  wire        tick;

  assign tick = (tick_cnt == TICK_CYCLES - 1);

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      tick_cnt <= 32'h0000_0000;
    else if (clk_en_in)
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
  end

  // -------------------------------------------------------------
  // Start-up delay and auto-zero timers
  // -------------------------------------------------------------
  reg  [9:0] startup_cnt;
  reg  [7:0] az_cnt;
  wire       az_forced;

  assign az_forced = freq_var && (az_cnt >= autozero_time_out);

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      startup_cnt        <= 10'h000;
      measure_enable_out <= 1'b0;
      az_cnt             <= 8'h00;
    end else if (clk_en_in) begin
      if (!measure_enable_out) begin
        if (!freq_var || startup_cnt >= startup_delay_time)
          measure_enable_out <= 1'b1;
        else if (tick)
          startup_cnt <= startup_cnt + 10'h001;
      end
      if (rise[4])
        az_cnt <= 8'h00;
      else if (tick && az_cnt != 8'hFF)
        az_cnt <= az_cnt + 8'h01;
    end
  end

  // -------------------------------------------------------------
  // Averaging of raw samples
  // -------------------------------------------------------------
  reg  [15:0] hist [0:7];
  reg  [3:0]  fill;
  reg  [18:0] sum;
  reg  [3:0]  avg_n;
  reg  [15:0] mean;
  integer     i;
  integer     j;

  always @* begin
    case (averaging_count)
      2'h1:    avg_n = 4'h2;
      2'h2:    avg_n = 4'h4;
      2'h3:    avg_n = 4'h8;
      default: avg_n = 4'h1;
    endcase
  end

  always @* begin
    sum = 19'h0_0000;
    for (i = 0; i < 8; i = i + 1) begin
      if (i < avg_n)
        sum = sum + {3'h0, hist[i]};
    end
    case (averaging_count)
      2'h1:    mean = sum[16:1];
      2'h2:    mean = sum[17:2];
      2'h3:    mean = sum[18:3];
      default: mean = sum[15:0];
    endcase
  end

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (j = 0; j < 8; j = j + 1)
        hist[j] <= 16'h0000;
      fill <= 4'h0;
    end else if (clk_en_in && measure_enable_out && raw_valid_in) begin
      hist[0] <= raw_value_in;
      for (j = 1; j < 8; j = j + 1)
        hist[j] <= hist[j-1];
      if (fill != 4'h8)
        fill <= fill + 4'h1;
    end
  end

  // Readout register, one strobe per new value
  reg sample_d;

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sample_d          <= 1'b0;
      readout_out       <= 16'h0000;
      readout_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      sample_d          <= measure_enable_out && raw_valid_in;
      readout_valid_out <= 1'b0;
      if (az_forced && measure_enable_out) begin
        if (readout_out != 16'h0000 || sample_d) begin
          readout_out       <= 16'h0000;
          readout_valid_out <= 1'b1;
        end
      end else if (sample_d && fill >= avg_n) begin
        readout_out       <= mean;
        readout_valid_out <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // Comparative outputs
  // -------------------------------------------------------------
  // one comparator per output
  limit_comparator u_cmp1 (
    .mclk_in     (mclk_in),
    .sys_rst_in  (sys_rst_in),
    .clk_en_in   (clk_en_in),
    .enable_in   (measure_enable_out),
    .sample_in   (readout_valid_out),
    .readout_in  (readout_out),
    .limit_hi_in (limit1_hi_in),
    .limit_lo_in (limit1_lo_in),
    .hyst_in     (hyst1_out),
    .mode_in     (out1_mode_out),
    .active_out  (out1_out)
  );

  limit_comparator u_cmp2 (
    .mclk_in     (mclk_in),
    .sys_rst_in  (sys_rst_in),
    .clk_en_in   (clk_en_in),
    .enable_in   (measure_enable_out),
    .sample_in   (readout_valid_out),
    .readout_in  (readout_out),
    .limit_hi_in (limit2_hi_in),
    .limit_lo_in (limit2_lo_in),
    .hyst_in     (hyst2_out),
    .mode_in     (out2_mode_out),
    .active_out  (out2_out)
  );

  // -------------------------------------------------------------
  // Setting menu
  // -------------------------------------------------------------
  reg  [31:0] hold_cnt;
  reg         hold_used;
  reg  [13:0] cur_value;
  reg  [13:0] max_value;
  reg  [3:0]  next_param;
  reg  [13:0] pwd_entry;

  // Value and range of the selected parameter
  always @* begin
    case (param_sel_out)
      `P_OUT1: begin
        cur_value = {12'h000, out1_mode_out};
        max_value = `MODE_MAX;
      end
      `P_OUT2: begin
        cur_value = {12'h000, out2_mode_out};
        max_value = `MODE_MAX;
      end
      `P_AVG: begin
        cur_value = {12'h000, averaging_count};
        max_value = `AVG_MAX;
      end
      `P_HYS1: begin
        cur_value = hyst1_out;
        max_value = `HYS_MAX;
      end
      `P_HYS2: begin
        cur_value = hyst2_out;
        max_value = `HYS_MAX;
      end
      `P_AZ: begin
        cur_value = {6'h00, autozero_time_out};
        max_value = `AZ_MAX;
      end
      `P_SU: begin
        cur_value = {4'h0, startup_delay_time};
        max_value = `SU_MAX;
      end
      default: begin
        cur_value = pwd_entry;
        max_value = `HYS_MAX;
      end
    endcase
  end

  always @* begin
    case (param_sel_out)
      `P_OUT1: next_param = `P_OUT2;
      `P_OUT2: next_param = `P_PWD;
      `P_AVG:  next_param = `P_HYS1;
      `P_HYS1: next_param = `P_HYS2;
      `P_HYS2: next_param = freq_var ? `P_AZ : `P_AVG;
      `P_AZ:   next_param = `P_SU;
      `P_SU:   next_param = `P_AVG;
      default: next_param = `P_OUT1;
    endcase
  end

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hold_cnt           <= 32'h0000_0000;
      hold_used          <= 1'b0;
      level_code_out     <= `LVL_OPER;
      param_sel_out      <= `P_OUT1;
      show_value_out     <= 1'b0;
      blink_out          <= 1'b0;
      edit_value_out     <= 14'h0000;
      pwd_entry          <= 14'h0000;
      averaging_count    <= `AVG_OFF;
      hyst1_out          <= `HYS_RESET;
      hyst2_out          <= `HYS_RESET;
      autozero_time_out  <= `AZ_RESET;
      startup_delay_time <= `SU_RESET;
      out1_mode_out      <= `MODE_UPPER;
      out2_mode_out      <= `MODE_UPPER;
    end else if (clk_en_in) begin
      if (!lvl_key) begin
        hold_cnt  <= 32'h0000_0000;
        hold_used <= 1'b0;
      end else if (!hold_used)
        hold_cnt <= hold_cnt + 32'h0000_0001;
      if (lvl_key && !hold_used && level_code_out == `LVL_OPER &&
          hold_cnt == HOLD_LONG_CYCLES - 1) begin
        hold_used      <= 1'b1;
        level_code_out <= `LVL_INIT;
        param_sel_out  <= `P_OUT1;
        show_value_out <= 1'b0;
        blink_out      <= 1'b0;
      end else if (lvl_key && !hold_used &&
                   level_code_out != `LVL_OPER &&
                   hold_cnt == HOLD_SHORT_CYCLES - 1) begin
        hold_used      <= 1'b1;
        level_code_out <= (level_code_out == `LVL_ADV) ?
                          `LVL_INIT : `LVL_OPER;
        param_sel_out  <= `P_OUT1;
        show_value_out <= 1'b0;
        blink_out      <= 1'b0;
      end else if (level_code_out != `LVL_OPER) begin
        if (rise[2] && !show_value_out)
          show_value_out <= 1'b1;
        else if (rise[2] && !blink_out) begin
          blink_out      <= 1'b1;
          edit_value_out <= cur_value;
        end else if (rise[3] && blink_out)
          edit_value_out <= (edit_value_out >= max_value) ?
                            14'h0000 : edit_value_out + 14'h0001;
        if (rise[1]) begin
          param_sel_out  <= next_param;
          show_value_out <= 1'b0;
          blink_out      <= 1'b0;
          if (blink_out) begin
            case (param_sel_out)
              `P_OUT1: out1_mode_out      <= edit_value_out[1:0];
              `P_OUT2: out2_mode_out      <= edit_value_out[1:0];
              `P_AVG:  averaging_count    <= edit_value_out[1:0];
              `P_HYS1: hyst1_out          <= edit_value_out;
              `P_HYS2: hyst2_out          <= edit_value_out;
              `P_AZ:   autozero_time_out  <= edit_value_out[7:0];
              `P_SU:   startup_delay_time <= edit_value_out[9:0];
              default: pwd_entry          <= edit_value_out;
            endcase
          end
          if (param_sel_out == `P_PWD && blink_out &&
              edit_value_out == `PWD_VALUE) begin
            level_code_out <= `LVL_ADV;
            param_sel_out  <= `P_AVG;
            pwd_entry      <= 14'h0000;
          end
        end
      end
    end
  end

endmodule

// file: meter_measure_settings_chk.sv
// Purpose: Port checker for meter_measure_settings
// Assumes: One clock domain, async active high reset
// Notes:   Bound from the bench top file
`timescale 1ns/1ns
`include "meter_consts.vh"

module meter_measure_settings_chk #(
  parameter HOLD_SHORT_CYCLES = 20,
  parameter HOLD_LONG_CYCLES  = 60,
  parameter TICK_CYCLES       = 10
) (
  // Clock and inputs
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        clk_en_in,
  input wire logic        level_key_in,
  input wire logic        raw_valid_in,
  input wire logic [15:0] limit1_hi_in,
  // Outputs
  input wire logic [15:0] readout_out,
  input wire logic        readout_valid_out,
  input wire logic        out1_out,
  input wire logic        out2_out,
  input wire logic        measure_enable_out,
  input wire logic [1:0]  level_code_out,
  input wire logic        show_value_out,
  input wire logic        blink_out,
  input wire logic [1:0]  averaging_count,
  input wire logic [13:0] hyst1_out,
  input wire logic [13:0] hyst2_out,
  input wire logic [7:0]  autozero_time_out,
  input wire logic [9:0]  startup_delay_time,
  input wire logic [1:0]  out1_mode_out
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [31:0] hold_len;
  logic        key_q;
  logic [16:0] h1;
  logic [16:0] up_sum;
  logic [16:0] hi;

  assign h1     = (hyst1_out == 14'h0000) ? 17'h0_0001 : {3'h0, hyst1_out};
  assign up_sum = {1'b0, readout_out} + h1;
  assign hi     = {1'b0, limit1_hi_in};

  // Length of the latest level key press, kept after release
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_q    <= 1'b0;
      hold_len <= 32'h0000_0000;
    end else begin
      key_q <= level_key_in;
      if (level_key_in && !key_q)
        hold_len <= 32'h0000_0001;
      else if (level_key_in)
        hold_len <= hold_len + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_take;
    raw_valid_in && clk_en_in && measure_enable_out
      && averaging_count == `AVG_OFF;
  endsequence
  sequence s_answer;
    ##2 readout_valid_out;
  endsequence
  sequence s_upper;
    readout_valid_out && out1_mode_out == `MODE_UPPER && measure_enable_out
      && clk_en_in;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_readout_latency: assert property (
    s_take |-> s_answer) else $error("readout not two cycles after sample");
  chk_upper_on: assert property (
    s_upper ##0 (readout_out >= limit1_hi_in) |=> out1_out)
    else $error("output one not on at limit");
  chk_upper_off: assert property (
    s_upper ##0 (up_sum <= hi) |=> !out1_out)
    else $error("output one not off past hysteresis");
  chk_upper_hold: assert property (
    s_upper ##0 (out1_out && up_sum > hi) |=> out1_out)
    else $error("output one left inside hysteresis");
  chk_hyst_range: assert property (
    hyst1_out <= `HYS_MAX && hyst2_out <= `HYS_MAX)
    else $error("hysteresis out of range");
  chk_autozero_range: assert property (
    {6'h00, autozero_time_out} <= `AZ_MAX) else $error("auto-zero range");
  chk_startup_range: assert property (
    {4'h0, startup_delay_time} <= `SU_MAX) else $error("start-up range");
  chk_level_step: assert property (
    $changed(level_code_out) |-> level_code_out == `LVL_INIT
      || $past(level_code_out) == `LVL_INIT)
    else $error("illegal level step");
  chk_long_hold: assert property (
    $past(level_code_out) == `LVL_OPER && level_code_out == `LVL_INIT
      |-> hold_len >= HOLD_LONG_CYCLES) else $error("level entered early");
  chk_short_hold: assert property (
    level_code_out < $past(level_code_out)
      |-> hold_len >= HOLD_SHORT_CYCLES) else $error("level left early");
  chk_edit_order: assert property (
    $rose(blink_out) |-> $past(show_value_out))
    else $error("edit without show");
  chk_oper_quiet: assert property (
    level_code_out == `LVL_OPER && $past(level_code_out) == `LVL_OPER
      |-> !blink_out && !show_value_out) else $error("edit in operation");
  chk_no_measure: assert property (
    !measure_enable_out |-> !out1_out && !out2_out)
    else $error("output before measuring");
endmodule

// file: panel_model.sv
// Purpose: Operator keys and pulse source facing the meter
// Assumes: Keys high while pressed, idle low by pull-down
// Notes:   Key index 0 level, 1 mode, 2 shift, 3 up
`timescale 1ns/1ns

module panel_model #(
  parameter PULSE_GAP = 100
) (
  input  wire logic mclk_in,
  input  wire logic pulse_run_in,
  output wire logic level_key_out,
  output wire logic mode_key_out,
  output wire logic shift_key_out,
  output wire logic up_key_out,
  output logic      pulse_out
);
  logic [3:0] keys = 4'h0;
  logic [7:0] gap_cnt = 8'h00;

  assign level_key_out = keys[0];
  assign mode_key_out  = keys[1];
  assign shift_key_out = keys[2];
  assign up_key_out    = keys[3];
  initial pulse_out = 1'b0;

  // pulse gap far below the auto-zero time
  always @(posedge mclk_in) begin
    gap_cnt   <= (gap_cnt == 8'(PULSE_GAP - 1)) ? 8'h00 : gap_cnt + 8'h01;
    pulse_out <= pulse_run_in && gap_cnt < 8'h02;
  end

  task automatic tap(input int k);
    @(posedge mclk_in);
    keys[k] <= 1'b1;
    repeat (5) @(posedge mclk_in);
    keys[k] <= 1'b0;
    repeat (5) @(posedge mclk_in);
    #1;
  endtask

  task automatic hold_level(input int n);
    @(posedge mclk_in);
    keys[0] <= 1'b1;
    repeat (n) @(posedge mclk_in);
    keys[0] <= 1'b0;
    repeat (6) @(posedge mclk_in);
    #1;
  endtask
endmodule

// file: meter_measure_settings_bench.sv
// Purpose: Self-checking bench for meter_measure_settings
// Assumes: Frequency variant strap high, short hold counts
// Notes:   Keys and pulses come from panel_model
`timescale 1ns/1ns
`include "meter_consts.vh"

module meter_measure_settings_bench;
  logic        mclk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        clk_en_in = 1'b1;
  logic        freq_variant_in = 1'b1;
  logic        raw_valid_in = 1'b0;
  logic [15:0] raw_value_in = 16'h0000;
  logic [15:0] limit1_hi_in = 16'h0064;
  logic [15:0] limit1_lo_in = 16'h0000;
  logic [15:0] limit2_hi_in = 16'hFFFF;
  logic [15:0] limit2_lo_in = 16'h0000;
  logic        pulse_run = 1'b1;
  logic        level_key_in, mode_key_in, shift_key_in, up_key_in, pulse_in;
  logic [15:0] readout_out;
  logic        readout_valid_out, out1_out, out2_out, measure_enable_out;
  logic        show_value_out, blink_out;
  logic [1:0]  level_code_out, averaging_count, out1_mode_out, out2_mode_out;
  logic [3:0]  param_sel_out;
  logic [13:0] edit_value_out, hyst1_out, hyst2_out;
  logic [7:0]  autozero_time_out;
  logic [9:0]  startup_delay_time;
  int          num_errors = 0;
  int          tests_run = 0;

  always #20 mclk_in = ~mclk_in;

  meter_measure_settings #(.HOLD_SHORT_CYCLES(20), .HOLD_LONG_CYCLES(60),
    .TICK_CYCLES(10)) dut (.*);

  panel_model pm (.mclk_in(mclk_in), .pulse_run_in(pulse_run),
    .level_key_out(level_key_in), .mode_key_out(mode_key_in),
    .shift_key_out(shift_key_in), .up_key_out(up_key_in),
    .pulse_out(pulse_in));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sample(input logic [15:0] v);
    @(posedge mclk_in);
    raw_valid_in <= 1'b1;
    raw_value_in <= v;
    @(posedge mclk_in);
    raw_valid_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  task automatic enter(input int n, input logic [13:0] exp);
    pm.tap(2);
    check(show_value_out, 1'b1);
    pm.tap(2);
    check(blink_out, 1'b1);
    repeat (n) pm.tap(3);
    check(edit_value_out, exp);
    pm.tap(1);
  endtask

  task automatic open_adv;
    pm.hold_level(70);
    check(level_code_out, `LVL_INIT);
    pm.tap(1);
    pm.tap(1);
    enter(169, 14'h00A9);
    check(level_code_out, `LVL_ADV);
    check(param_sel_out, `P_AVG);
  endtask

  task automatic leave;
    pm.hold_level(28);
    check(level_code_out, `LVL_INIT);
    pm.hold_level(28);
    check(level_code_out, `LVL_OPER);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    #1;
    check(hyst1_out, 14'h0001);
    check(hyst2_out, 14'h0001);
    check(autozero_time_out, `AZ_RESET);
    check(averaging_count, `AVG_OFF);
    check(measure_enable_out, 1'b1);
  endtask

  task automatic t_compare(input int h);
    for (int i = 0; i <= h; i++) begin
      sample(16'h0064 - 16'(i));
      check(readout_out, 16'h0064 - 16'(i));
      @(posedge mclk_in);
      #1;
      check(out1_out, i < h);
    end
  endtask

  task automatic t_out2;
    pm.hold_level(70);
    pm.tap(1);
    enter(2, 14'h0002);
    check(out2_mode_out, `MODE_OUTSIDE);
    pm.hold_level(28);
    check(level_code_out, `LVL_OPER);
    @(posedge mclk_in);
    limit2_hi_in <= 16'h0066;
    limit2_lo_in <= 16'h0062;
    limit1_lo_in <= 16'h0010;
    for (int i = 0; i < 3; i++) begin
      sample(16'h0066 - 16'(2 * i));
      @(posedge mclk_in);
      #1;
      check(out2_out, i != 1);
    end
    // Frozen clock enable must ignore a sample
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    sample(16'h0064);
    check(out2_out, 1'b1);
    check(readout_out, 16'h0062);
    @(posedge mclk_in);
    clk_en_in <= 1'b1;
  endtask

  task automatic t_nav;
    pm.hold_level(30);
    check(level_code_out, `LVL_OPER);
    open_adv;
    pm.tap(1);
    check(averaging_count, `AVG_OFF);
    enter(1, 14'h0002);
    check(hyst1_out, 14'h0002);
    leave;
  endtask

  task automatic t_avg;
    open_adv;
    pm.tap(2);
    pm.tap(2);
    for (int k = 1; k <= 3; k++) begin
      pm.tap(3);
      check(edit_value_out, 14'(k));
    end
    pm.tap(1);
    check(averaging_count, 2'h3);
    leave;
    for (int k = 1; k <= 8; k++)
      sample(16'(k));
    check(readout_out, 16'h0004);
    sample(16'h0010);
    check(readout_out, 16'h0006);
  endtask

  task automatic t_autozero;
    @(posedge mclk_in);
    pulse_run <= 1'b0;
    repeat (350) @(posedge mclk_in);
    #1;
    check(readout_out, 16'h0006);
    repeat (250) @(posedge mclk_in);
    #1;
    check(readout_out, 16'h0000);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    stop_test;
  end

  initial begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    t_reset;
    t_compare(1);
    t_nav;
    t_compare(2);
    t_out2;
    t_avg;
    t_autozero;
    stop_test;
  end
endmodule

bind meter_measure_settings meter_measure_settings_chk #(
  .HOLD_SHORT_CYCLES(HOLD_SHORT_CYCLES), .HOLD_LONG_CYCLES(HOLD_LONG_CYCLES),
  .TICK_CYCLES(TICK_CYCLES)) chk (.*);
